/* i2c_ms_pkg.sv */
// Purpose: Shared constants and state list for the I2C master sequencer.
// Assumes: APB with 32-bit data, one word per register.
// Notes: Byte offsets below are the APB addresses.
package i2c_ms_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_RATE = 8'h08;
    localparam logic [7:0] OFS_BUF = 8'h0C;
    // Control register fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_START = 1;
    localparam int CTRL_RESTART = 2;
    localparam int CTRL_HALT = 3;
    localparam int CTRL_ACK = 4;
    localparam int CTRL_ACKLVL = 5;
    localparam int CTRL_IRQEN = 6;
    // Status register fields
    localparam int ST_FULL = 0;
    localparam int ST_WRITE_COLLISION_FLAG = 1;
    localparam int ST_IRQ = 2;
    localparam int ST_ARB = 3;
    localparam int ST_SDET = 4;
    localparam int ST_PDET = 5;
    localparam int ST_ACKSTAT = 6;
    localparam int ST_BUSY = 7;
    // Reset values and sizes
    localparam logic [6:0] RATE_RST = 7'h09;
    localparam logic [3:0] BITS_PER_FRAME = 4'h9;
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [2:0] SYNC_RST = 3'h7;
    // Sequencer states
    typedef enum logic [4:0] {
        S_IDLE, S_ST_CHK, S_ST_A, S_ST_B,
        S_RS_A, S_RS_B, S_RS_C, S_RS_D, S_RS_E, S_RS_F,
        S_TX_LOW, S_TX_REL, S_TX_HIGH,
        S_AK_LOW, S_AK_REL, S_AK_HIGH,
        S_SP_A, S_SP_B, S_SP_C, S_SP_D, S_SP_E
    } state_t;
endpackage

/* i2c_master_seq.sv */
// Purpose: I2C master acknowledge, stop, start and collision sequencing with APB access.
// Assumes: Open-drain pins, rate counter ticks at zero, pins sampled on CLK_SYS.
// Notes: Control bits accept new sequences only while idle and enabled.
`timescale 1ns/1ns
module i2c_master_seq (
    input wire logic CLK_SYS, // System clock, 20 MHz
    input wire logic RST, // Synchronous reset, active high
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB access phase
    input wire logic PWRITE, // APB direction
    input wire logic [7:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error on unmapped address
    input wire logic SCL_IN, // SCL pin level
    output logic SCL_OUT, // SCL pin drive value, always low
    output logic SCL_OE, // SCL pull low when high
    input wire logic SDA_IN, // SDA pin level
    output logic SDA_OUT, // SDA pin drive value, always low
    output logic SDA_OE, // SDA pull low when high
    input wire logic SLEEP, // Processor asleep
    output logic WAKE, // Wake request to processor
    output logic IRQ // Port interrupt flag
);
    typedef struct packed {
        i2c_ms_pkg::state_t st;
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_f;
        logic sda_f;
        logic scl_p;
        logic sda_p;
        logic [6:0] cnt;
        logic run;
        logic en;
        logic start_en;
        logic restart_en;
        logic halt_sequence_enable;
        logic ack_sequence_enable;
        logic ack_level_bit;
        logic irq_en;
        logic [6:0] rate;
        logic [7:0] buf_v;
        logic [7:0] shf;
        logic [3:0] bitn;
        logic buffer_full_flag;
        logic write_collision_flag;
        logic serial_port_irq_flag;
        logic arbitration_loss_flag;
        logic s_det;
        logic p_det;
        logic ack_stat;
        logic scl_oe;
        logic sda_oe;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic wake;
    } regs_t;

    regs_t q;
    regs_t r;

    // Collision: abort whatever runs, release both lines, drop sequence enables
    function automatic regs_t collide(input regs_t x);
        regs_t y;
        y = x;
        y.arbitration_loss_flag = 1'b1;
        y.st = i2c_ms_pkg::S_IDLE;
        y.scl_oe = 1'b0;
        y.sda_oe = 1'b0;
        y.buffer_full_flag = 1'b0;
        y.start_en = 1'b0;
        y.restart_en = 1'b0;
        y.halt_sequence_enable = 1'b0;
        y.ack_sequence_enable = 1'b0;
        y.run = 1'b0;
        return y;
    endfunction

    // Rate counter load; a reload of zero still gives one cycle
    function automatic regs_t reload(input regs_t x);
        regs_t y;
        y = x;
        y.cnt = x.rate;
        y.run = 1'b1;
        return y;
    endfunction

    // Next-state logic for the whole block
    always_comb begin
        logic tick;
        logic busy;
        logic acc;
        logic [7:0] stat;
        r = q;
        tick = q.run && (q.cnt == 7'h00);
        busy = (q.st != i2c_ms_pkg::S_IDLE);
        acc = PSEL && PENABLE;
        stat = {busy, q.ack_stat, q.p_det, q.s_det, q.arbitration_loss_flag,
                q.serial_port_irq_flag, q.write_collision_flag, q.buffer_full_flag};
        if (q.run && (q.cnt != 7'h00)) begin
            r.cnt = q.cnt - 7'h01;
        end
        // Three-stage pin filter; level changes once stages two and three agree
        r.scl_s = {q.scl_s[1:0], SCL_IN};
        r.sda_s = {q.sda_s[1:0], SDA_IN};
        if (q.scl_s[1] == q.scl_s[2]) begin
            r.scl_f = q.scl_s[2];
        end
        if (q.sda_s[1] == q.sda_s[2]) begin
            r.sda_f = q.sda_s[2];
        end
        r.scl_p = q.scl_f;
        r.sda_p = q.sda_f;

        // APB: one wait state, so prdata and pslverr are registered
        r.pready = 1'b0;
        if (acc && !q.pready) begin
            r.pready = 1'b1;
            r.pslverr = 1'b0;
            r.prdata = 32'h0000_0000;
            if (PADDR == i2c_ms_pkg::OFS_CTRL) begin
                r.prdata[6:0] = {q.irq_en, q.ack_level_bit, q.ack_sequence_enable,
                                 q.halt_sequence_enable, q.restart_en, q.start_en, q.en};
            end else if (PADDR == i2c_ms_pkg::OFS_STATUS) begin
                r.prdata[7:0] = stat;
            end else if (PADDR == i2c_ms_pkg::OFS_RATE) begin
                r.prdata[6:0] = q.rate;
            end else if (PADDR == i2c_ms_pkg::OFS_BUF) begin
                r.prdata[7:0] = q.buf_v;
            end else begin
                r.pslverr = 1'b1;
            end
        end else if (acc && q.pready && PWRITE) begin
            // Write lands on the edge that completes the transfer
            if (PADDR == i2c_ms_pkg::OFS_CTRL) begin
                r.en = PWDATA[i2c_ms_pkg::CTRL_EN];
                r.irq_en = PWDATA[i2c_ms_pkg::CTRL_IRQEN];
                r.ack_level_bit = PWDATA[i2c_ms_pkg::CTRL_ACKLVL];
                // No queueing: sequence bits only taken while idle
                if (!busy && PWDATA[i2c_ms_pkg::CTRL_EN]) begin
                    r.start_en = PWDATA[i2c_ms_pkg::CTRL_START];
                    r.restart_en = PWDATA[i2c_ms_pkg::CTRL_RESTART];
                    r.halt_sequence_enable = PWDATA[i2c_ms_pkg::CTRL_HALT];
                    r.ack_sequence_enable = PWDATA[i2c_ms_pkg::CTRL_ACK];
                end
            end else if (PADDR == i2c_ms_pkg::OFS_STATUS) begin
                // Write one to clear; hardware sets below win
                if (PWDATA[i2c_ms_pkg::ST_WRITE_COLLISION_FLAG]) r.write_collision_flag = 1'b0;
                if (PWDATA[i2c_ms_pkg::ST_IRQ]) r.serial_port_irq_flag = 1'b0;
                if (PWDATA[i2c_ms_pkg::ST_ARB]) r.arbitration_loss_flag = 1'b0;
            end else if (PADDR == i2c_ms_pkg::OFS_RATE) begin
                r.rate = PWDATA[6:0];
            end else if (PADDR == i2c_ms_pkg::OFS_BUF) begin
                if (busy || q.buffer_full_flag || !q.en) begin
                    r.write_collision_flag = 1'b1;
                end else begin
                    // Always restart from bit 7 of the new byte
                    r.buf_v = PWDATA[7:0];
                    r.shf = PWDATA[7:0];
                    r.bitn = 4'h0;
                    r.buffer_full_flag = 1'b1;
                    r.st = i2c_ms_pkg::S_TX_LOW;
                    r.scl_oe = 1'b1;
                    r.sda_oe = !PWDATA[7];
                    r = reload(r);
                end
            end
        end

        // Sequencer; each case runs on filtered pin levels
        case (q.st)
            i2c_ms_pkg::S_IDLE: begin
                // Keep the count that a buffer write has just started
                if (r.st == i2c_ms_pkg::S_IDLE) begin
                    r.run = 1'b0;
                end
                if (q.start_en) begin
                    r.st = i2c_ms_pkg::S_ST_CHK;
                end else if (q.restart_en) begin
                    r.scl_oe = 1'b1;
                    r.st = i2c_ms_pkg::S_RS_A;
                end else if (q.ack_sequence_enable) begin
                    r.scl_oe = 1'b1;
                    r.sda_oe = !q.ack_level_bit;
                    r.st = i2c_ms_pkg::S_AK_LOW;
                    r = reload(r);
                end else if (q.halt_sequence_enable) begin
                    r.scl_oe = 1'b1;
                    r.sda_oe = 1'b1;
                    r.st = i2c_ms_pkg::S_SP_A;
                end
            end
            i2c_ms_pkg::S_ST_CHK: begin
                if (!q.sda_f || !q.scl_f) begin
                    r = collide(r);
                end else begin
                    r.st = i2c_ms_pkg::S_ST_A;
                    r = reload(r);
                end
            end
            i2c_ms_pkg::S_ST_A: begin
                if (!q.scl_f) begin
                    r = collide(r);
                end else if (!q.sda_f || tick) begin
                    // Another master won SDA first: assert at once, not a loss
                    r.sda_oe = 1'b1;
                    r.st = i2c_ms_pkg::S_ST_B;
                    r = reload(r);
                end
            end
            i2c_ms_pkg::S_ST_B: begin
                if (tick) begin
                    r.scl_oe = 1'b1;
                    r.start_en = 1'b0;
                    r.serial_port_irq_flag = 1'b1;
                    r.st = i2c_ms_pkg::S_IDLE;
                end
            end
            i2c_ms_pkg::S_RS_A: begin
                if (!q.scl_f) begin
                    r.sda_oe = 1'b0;
                    r.st = i2c_ms_pkg::S_RS_B;
                end
            end
            i2c_ms_pkg::S_RS_B: begin
                if (q.sda_f) begin
                    r.st = i2c_ms_pkg::S_RS_C;
                    r = reload(r);
                end
            end
            i2c_ms_pkg::S_RS_C: begin
                if (tick) begin
                    r.scl_oe = 1'b0;
                    r.run = 1'b0;
                    r.st = i2c_ms_pkg::S_RS_D;
                end
            end
            i2c_ms_pkg::S_RS_D: begin
                if (q.scl_f) begin
                    if (!q.sda_f) begin
                        r = collide(r);
                    end else begin
                        r.st = i2c_ms_pkg::S_RS_E;
                        r = reload(r);
                    end
                end
            end
            i2c_ms_pkg::S_RS_E: begin
                if (!q.scl_f && q.sda_f) begin
                    r = collide(r);
                end else if (tick) begin
                    r.sda_oe = 1'b1;
                    r.st = i2c_ms_pkg::S_RS_F;
                    r = reload(r);
                end
            end
            i2c_ms_pkg::S_RS_F: begin
                if (tick) begin
                    r.scl_oe = 1'b1;
                    r.restart_en = 1'b0;
                    r.serial_port_irq_flag = 1'b1;
                    r.st = i2c_ms_pkg::S_IDLE;
                end
            end
            i2c_ms_pkg::S_TX_LOW: begin
                if (tick) begin
                    r.scl_oe = 1'b0;
                    r.run = 1'b0;
                    r.st = i2c_ms_pkg::S_TX_REL;
                end
            end
            i2c_ms_pkg::S_TX_REL: begin
                // Clock stretching: high time counts from SCL seen high
                if (q.scl_f) begin
                    r.st = i2c_ms_pkg::S_TX_HIGH;
                    r = reload(r);
                end
            end
            i2c_ms_pkg::S_TX_HIGH: begin
                if (!q.sda_oe && !q.sda_f && q.bitn < i2c_ms_pkg::DATA_BITS) begin
                    r = collide(r);
                end else if (tick) begin
                    r.scl_oe = 1'b1;
                    r.bitn = q.bitn + 4'h1;
                    r.shf = {q.shf[6:0], 1'b0};
                    if (q.bitn == i2c_ms_pkg::DATA_BITS) begin
                        r.ack_stat = q.sda_f;
                        r.sda_oe = 1'b0;
                        r.run = 1'b0;
                        r.serial_port_irq_flag = 1'b1;
                        r.st = i2c_ms_pkg::S_IDLE;
                    end else begin
                        r.sda_oe = (q.bitn + 4'h1 < i2c_ms_pkg::DATA_BITS) && !q.shf[6];
                        if (q.bitn + 4'h1 == i2c_ms_pkg::DATA_BITS) begin
                            r.buffer_full_flag = 1'b0;
                        end
                        r.st = i2c_ms_pkg::S_TX_LOW;
                        r = reload(r);
                    end
                end
            end
            i2c_ms_pkg::S_AK_LOW: begin
                if (tick) begin
                    r.scl_oe = 1'b0;
                    r.run = 1'b0;
                    r.st = i2c_ms_pkg::S_AK_REL;
                end
            end
            i2c_ms_pkg::S_AK_REL: begin
                if (q.scl_f) begin
                    r.st = i2c_ms_pkg::S_AK_HIGH;
                    r = reload(r);
                end
            end
            i2c_ms_pkg::S_AK_HIGH: begin
                if (q.ack_level_bit && !q.sda_f) begin
                    r = collide(r);
                end else if (tick) begin
                    r.scl_oe = 1'b1;
                    r.ack_sequence_enable = 1'b0;
                    r.run = 1'b0;
                    r.st = i2c_ms_pkg::S_IDLE;
                end
            end
            i2c_ms_pkg::S_SP_A: begin
                if (!q.sda_f) begin
                    r.st = i2c_ms_pkg::S_SP_B;
                    r = reload(r);
                end
            end
            i2c_ms_pkg::S_SP_B: begin
                if (tick) begin
                    r.scl_oe = 1'b0;
                    r.st = i2c_ms_pkg::S_SP_C;
                    r = reload(r);
                end
            end
            i2c_ms_pkg::S_SP_C: begin
                if (tick) begin
                    r.sda_oe = 1'b0;
                    r.run = 1'b0;
                    r.st = i2c_ms_pkg::S_SP_D;
                end
            end
            i2c_ms_pkg::S_SP_D: begin
                if (q.sda_f && q.scl_f) begin
                    r.p_det = 1'b1;
                    r.s_det = 1'b0;
                    r.st = i2c_ms_pkg::S_SP_E;
                    r = reload(r);
                end
            end
            i2c_ms_pkg::S_SP_E: begin
                if (tick) begin
                    r.halt_sequence_enable = 1'b0;
                    r.serial_port_irq_flag = 1'b1;
                    r.run = 1'b0;
                    r.st = i2c_ms_pkg::S_IDLE;
                end
            end
            default: begin
                r.st = i2c_ms_pkg::S_IDLE;
            end
        endcase

        // Bus monitor keeps running after a loss and in sleep
        if (q.sda_f && !q.sda_p && q.scl_f && q.scl_p) begin
            r.p_det = 1'b1;
            r.s_det = 1'b0;
            // Own stop raises its flag one period later instead
            if (q.st != i2c_ms_pkg::S_SP_D) begin
                r.serial_port_irq_flag = 1'b1;
            end
        end else if (!q.sda_f && q.sda_p && q.scl_f && q.scl_p) begin
            r.s_det = 1'b1;
            r.p_det = 1'b0;
        end

        // Disabled port: abort transfer, free lines, forget bus state
        if (!q.en) begin
            r.st = i2c_ms_pkg::S_IDLE;
            r.scl_oe = 1'b0;
            r.sda_oe = 1'b0;
            r.run = 1'b0;
            r.s_det = 1'b0;
            r.p_det = 1'b0;
            r.buffer_full_flag = 1'b0;
            r.start_en = 1'b0;
            r.restart_en = 1'b0;
            r.halt_sequence_enable = 1'b0;
            r.ack_sequence_enable = 1'b0;
        end

        // Wake only when the flag could interrupt the processor
        r.wake = r.serial_port_irq_flag && q.irq_en && SLEEP;
    end

    // State register; reset frees the bus and clears all control
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            q <= '0;
            q.st <= i2c_ms_pkg::S_IDLE;
            q.rate <= i2c_ms_pkg::RATE_RST;
            q.scl_s <= i2c_ms_pkg::SYNC_RST;
            q.sda_s <= i2c_ms_pkg::SYNC_RST;
            q.scl_f <= 1'b1;
            q.sda_f <= 1'b1;
            q.scl_p <= 1'b1;
            q.sda_p <= 1'b1;
        end else begin
            q <= r;
        end
    end

    // Outputs straight from flops; pins only ever pull low
    assign PRDATA = q.prdata;
    assign PREADY = q.pready;
    assign PSLVERR = q.pslverr;
    assign SCL_OUT = 1'b0;
    assign SCL_OE = q.scl_oe;
    assign SDA_OUT = 1'b0;
    assign SDA_OE = q.sda_oe;
    assign WAKE = q.wake;
    assign IRQ = q.serial_port_irq_flag;
endmodule

/* i2c_bus_partner.sv */
// Purpose: Wired bus standing in for other masters and slaves.
// Assumes: Pull-ups on both lines.
// Notes: Holds SDA low only when the bench asks.
`timescale 1ns/1ns
module i2c_bus_partner (
    input wire logic scl_oe_m, // Master pulls SCL low
    input wire logic sda_oe_m, // Master pulls SDA low
    input wire logic grab_sda, // Other master pulls SDA low
    output logic scl, // Wired SCL level
    output logic sda // Wired SDA level
);
    // Released lines float high through the pull-ups, never hold old data
    assign scl = !scl_oe_m;
    assign sda = !(sda_oe_m || grab_sda);
endmodule

/* i2c_master_seq_checker.sv */
// Purpose: Port-level checks for the I2C master sequencer.
// Assumes: Rate reload stays small, so waits fit in 300 cycles.
// Notes: Sequence bits are only written while the port is idle.
`timescale 1ns/1ns
module i2c_master_seq_checker (
    input wire logic CLK_SYS, // Clock
    input wire logic RST, // Reset
    input wire logic PSEL, // Select
    input wire logic PENABLE, // Access
    input wire logic PWRITE, // Direction
    input wire logic [7:0] PADDR, // Address
    input wire logic [31:0] PWDATA, // Write data
    input wire logic PREADY, // Ready
    input wire logic SCL_IN, // SCL level
    input wire logic SCL_OE, // SCL pulled
    input wire logic SDA_IN, // SDA level
    input wire logic SDA_OE, // SDA pulled
    input wire logic SLEEP, // Asleep
    input wire logic WAKE, // Wake
    input wire logic IRQ // Port flag
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    logic wr_c;
    logic lvl_q;
    // Enabled control write taking effect
    assign wr_c = PSEL && PENABLE && PREADY && PWRITE && (PADDR == i2c_ms_pkg::OFS_CTRL)
        && PWDATA[i2c_ms_pkg::CTRL_EN];
    // Level that the acknowledge must show on SDA
    always_ff @(posedge CLK_SYS) begin
        if (wr_c) begin
            lvl_q <= PWDATA[i2c_ms_pkg::CTRL_ACKLVL];
        end
    end
    chk_ack_drive: assert property (
        wr_c && PWDATA[i2c_ms_pkg::CTRL_ACK] |-> ##[1:3] SCL_OE && (SDA_OE == !lvl_q))
        else $error("ack drive wrong");
    chk_ack_release: assert property (
        wr_c && PWDATA[i2c_ms_pkg::CTRL_ACK] |-> ##[2:300] !SCL_OE)
        else $error("ack never released SCL");
    chk_halt_sda: assert property (
        wr_c && PWDATA[i2c_ms_pkg::CTRL_HALT] |-> ##[1:3] SDA_OE)
        else $error("stop did not pull SDA");
    chk_start_abort: assert property (
        !SDA_IN [*6] ##1 (wr_c && PWDATA[i2c_ms_pkg::CTRL_START] && !SDA_IN)
        |=> (!SDA_OE && !SCL_OE) [*8])
        else $error("start drove a busy bus");
    chk_bus_stop: assert property (
        $rose(SDA_IN) && SCL_IN |-> ##[1:300] IRQ)
        else $error("stop gave no flag");
    chk_apb_ready: assert property (PSEL && !PENABLE |-> ##2 PREADY)
        else $error("ready late");
    chk_apb_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready too long");
    chk_wake_sleep: assert property (WAKE |-> $past(SLEEP))
        else $error("wake while awake");
    chk_reset_idle: assert property (
        @(posedge CLK_SYS) disable iff (1'b0)
        RST |=> !SCL_OE && !SDA_OE && !IRQ && !WAKE && !PREADY)
        else $error("reset left port active");
    cover property (wr_c && PWDATA[i2c_ms_pkg::CTRL_ACK]);
    cover property (wr_c && PWDATA[i2c_ms_pkg::CTRL_HALT]);
    cover property (wr_c && PWDATA[i2c_ms_pkg::CTRL_RESTART]);
    cover property (WAKE);
endmodule
bind i2c_master_seq i2c_master_seq_checker i_chk (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
    .SCL_IN(SCL_IN), .SCL_OE(SCL_OE), .SDA_IN(SDA_IN), .SDA_OE(SDA_OE), .SLEEP(SLEEP),
    .WAKE(WAKE), .IRQ(IRQ));

/* i2c_master_ack_stop_arbitration_tb.sv */
// Purpose: Self-checking bench for the I2C master sequencer.
// Assumes: Pulled-up bus; the partner holds SDA low on command.
// Notes: Rate reload 2 makes each rate period three cycles.
`timescale 1ns/1ns
module i2c_master_ack_stop_arbitration_tb;
    localparam logic [7:0] a_ctl = i2c_ms_pkg::OFS_CTRL;
    localparam logic [7:0] a_st = i2c_ms_pkg::OFS_STATUS;
    localparam logic [7:0] a_buf = i2c_ms_pkg::OFS_BUF;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] q;
    logic pready;
    logic pslverr;
    logic err;
    logic scl_oe;
    logic sda_oe;
    logic scl;
    logic sda;
    logic grab = 1'b0;
    logic sleep = 1'b0;
    logic wake;
    logic irq;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    // 20 MHz clock
    always #25 clk_sys = !clk_sys;
    i2c_master_seq i_i2c_master_seq (.CLK_SYS(clk_sys), .RST(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .SCL_IN(scl), .SCL_OUT(), .SCL_OE(scl_oe),
        .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe), .SLEEP(sleep), .WAKE(wake), .IRQ(irq));
    i2c_bus_partner i_i2c_bus_partner (.scl_oe_m(scl_oe), .sda_oe_m(sda_oe),
        .grab_sda(grab), .scl(scl), .sda(sda));
    // Counts, verdict and end of run
    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One transfer, held until ready is seen; an edge passes before the next
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Read until masked bits match, bounded
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        int n = 0;
        apb(1'b0, a, 32'h0);
        while ((q & m) !== e && n < 200) begin
            apb(1'b0, a, 32'h0);
            n++;
        end
        chk(q & m, e);
    endtask
    task automatic wait_irq;
        int n = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(posedge clk_sys);
            n++;
        end
        chk(irq, 1'b1);
    endtask
    // Main sequence
    initial begin
        int n;
        n = 0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        poll(a_ctl, 32'hFFFFFFFF, 32'h0);
        poll(i2c_ms_pkg::OFS_RATE, 32'h7F, {25'h0, i2c_ms_pkg::RATE_RST});
        apb(1'b0, 8'h10, 32'h0);
        chk(err, 1'b1);
        chk(q, 32'h0);
        apb(1'b1, i2c_ms_pkg::OFS_RATE, 32'h2);
        apb(1'b1, a_ctl, 32'h41);
        poll(a_st, 32'h30, 32'h0);
        apb(1'b1, a_ctl, 32'h43);
        wait_irq();
        chk({scl_oe, sda_oe}, 2'b11);
        poll(a_st, 32'h3F, 32'h14);
        apb(1'b1, a_st, 32'h4);
        // Not-acknowledge picked up front; a buffer write collides
        apb(1'b1, a_ctl, 32'h71);
        apb(1'b1, a_buf, 32'hA5);
        poll(a_ctl, 32'h10, 32'h0);
        chk({scl_oe, irq}, 2'b10);
        poll(a_st, 32'h3, 32'h2);
        poll(a_buf, 32'hFF, 32'h0);
        apb(1'b1, a_st, 32'h2);
        // Stop after the frame, then wake a sleeping processor
        apb(1'b1, a_ctl, 32'h49);
        wait_irq();
        poll(a_ctl, 32'h8, 32'h0);
        chk({scl_oe, sda_oe}, 2'b00);
        poll(a_st, 32'h20, 32'h20);
        sleep <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(wake, 1'b1);
        sleep <= 1'b0;
        apb(1'b1, a_st, 32'h4);
        // Start refused on a bus held low, then the release is a stop
        grab <= 1'b1;
        repeat (8) @(posedge clk_sys);
        apb(1'b1, a_ctl, 32'h43);
        poll(a_st, 32'h8, 32'h8);
        chk({scl_oe, sda_oe}, 2'b00);
        poll(a_ctl, 32'h1E, 32'h0);
        apb(1'b1, a_st, 32'hE);
        grab <= 1'b0;
        wait_irq();
        apb(1'b1, a_st, 32'h4);
        // Floating one overridden by another master
        apb(1'b1, a_ctl, 32'h43);
        wait_irq();
        apb(1'b1, a_st, 32'h4);
        apb(1'b1, a_buf, 32'hFF);
        grab <= 1'b1;
        poll(a_st, 32'h9, 32'h8);
        chk({scl_oe, sda_oe}, 2'b00);
        apb(1'b1, a_st, 32'hE);
        grab <= 1'b0;
        wait_irq();
        apb(1'b1, a_st, 32'h4);
        // A new byte restarts at its first bit, a zero
        apb(1'b1, a_ctl, 32'h43);
        wait_irq();
        apb(1'b1, a_st, 32'h4);
        apb(1'b1, a_buf, 32'h7F);
        while (scl_oe !== 1'b0 && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        chk(scl_oe, 1'b0);
        chk(sda_oe, 1'b1);
        wait_irq();
        // Repeated start on the bus held after the byte
        apb(1'b1, a_st, 32'h4);
        apb(1'b1, a_ctl, 32'h45);
        wait_irq();
        chk({scl_oe, sda_oe}, 2'b11);
        poll(a_st, 32'h38, 32'h10);
        poll(a_ctl, 32'h4, 32'h0);
        // Disabling clears the bus state bits
        apb(1'b1, a_ctl, 32'h0);
        poll(a_st, 32'h31, 32'h0);
        summarize();
    end
    // Cut a hang short
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
endmodule
